// file: hdl/aamp_pkg.sv
// Contract
// - Device is slave only, never drives clock
// - Start and stop are data edges, clock high
// - Stop returns device to idle, abandons transfer
// - Host keeps data stable while clock high
// - Bytes MSB first, acknowledge on ninth clock
// - Device acknowledges every received write byte
// - Device releases data on ninth, samples ack
// - First byte bit eight selects read/write
// - Second byte is register address, then data
// - Further address/data pairs until stop
// - Address MSB is auto-increment flag
// - Auto-increment address wraps past top
// - Coefficient mode addresses hold four-byte words
// - Coefficient writes send four bytes MSB first
// - Coefficients committed when fifth one arrives (code commits only for addresses up to 0x4f)
// - Host reads via address, repeated start, read
// - Auto-increment reads continue while host acknowledges
// - Host NAKs last read byte, then stops
// - Quad reads return four bytes MSB first
// - Glitch filter on both lines, register 0x66
// - Upper seven bits compared with slave address
// - Address from select pin and reset strap
package aamp_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_LOW_NS      = 1300;
	localparam int SCL_QTR_CYC   =
		(T_LOW_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam logic [6:0] DEV_ADDR_BASE   = 7'h2a;
	localparam logic [6:0] COEF_TOP        = 7'h79;
	localparam logic [6:0] COEF_FILT_TOP   = 7'h4f;
	localparam logic [6:0] GLITCH_CFG_ADDR = 7'h66;
	localparam logic [7:0] GLITCH_CFG_RST  = 8'h03;
	localparam logic [3:0] SYNC_RST        = 4'h3;
	localparam logic [1:0] STRAP_SETTLE    = 2'h2;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
	localparam logic [3:0] ACK_DONE        = 4'h9;
	localparam logic [1:0] LAST_BYTE_IDX   = 2'h3;
	localparam logic [2:0] LAST_COEF_SLOT  = 3'h4;
	localparam logic [2:0] MAX_BYTES       = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_RD, ST_IGNORE
	} aamp_dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE, H_START, H_BIT, H_RESTART, H_STOP
	} aamp_host_state_t;

	function automatic logic [6:0] next_addr(input logic coef,
		input logic [6:0] a);
		next_addr = (coef && a == COEF_TOP) ? 7'h00 : 7'(a + 7'h01);
	endfunction

	function automatic logic [2:0] coef_slot(input logic [6:0] a);
		coef_slot = 3'(a % 7'h05);
	endfunction
endpackage

// file: hdl/aamp_link_if.sv
`timescale 1ns/10ps
interface aamp_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain lines with pull-up: any enabled low driver wins
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o,
		output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// file: hdl/aamp_i2c_dev.sv
`timescale 1ns/10ps
module aamp_i2c_dev (
	input  wire logic          core_clk,
	input  wire logic          nrst,
	aamp_link_if.dev           link,
	input  wire logic          addr_sel,
	input  wire logic          strap_in,
	input  wire logic          coef_mode,
	output logic [6:0]         reg_rd_addr,
	input  wire logic [31:0]   reg_rd_data,
	output logic               reg_wr_stb,
	output logic [6:0]         reg_wr_addr,
	output logic [7:0]         reg_wr_data,
	output logic               coef_wr_stb,
	output logic [6:0]         coef_wr_addr,
	output logic [31:0]        coef_wr_data,
	output logic               coef_commit_stb,
	output logic [6:0]         coef_commit_addr,
	output logic [159:0]       coef_commit_data,
	output logic [6:0]         slave_addr,
	output logic [7:0]         glitch_cfg,
	output logic               busy
);
	logic [3:0]                    s1_reg;
	logic [3:0]                    s2_reg;
	logic [1:0]                    filt_reg;
	logic [1:0]                    prev_reg;
	logic [3:0]                    fcnt_reg [2];
	logic [7:0]                    glitch_cfg_reg;
	logic [1:0]                    strap_cnt_reg;
	logic                          strap_done_reg;
	aamp_pkg::aamp_dev_state_t     state_reg;
	logic [3:0]                    bit_reg;
	logic [7:0]                    rx_reg;
	logic [7:0]                    tx_reg;
	logic                          ack_ok_reg;
	logic                          aif_reg;
	logic                          sda_drive_reg;
	logic [6:0]                    addr_reg;
	logic [1:0]                    bidx_reg;
	logic [23:0]                   word_reg;
	logic [31:0]                   stage_mem [4];
	logic                          scl_rise;
	logic                          scl_fall;
	logic                          start_cond;
	logic                          stop_cond;
	logic                          byte_done;
	logic                          word_done;
	logic [31:0]                   full_word;
	logic [7:0]                    rd_byte;
	logic [2:0]                    slot;

	// Order: scl, sda, address select, strap
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= aamp_pkg::SYNC_RST;
			s2_reg <= aamp_pkg::SYNC_RST;
		end else begin
			s1_reg <= {strap_in, addr_sel, link.sda, link.scl};
			s2_reg <= s1_reg;
		end
	end

	// Level accepted only after it holds past the configured length
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			filt_reg    <= 2'h3;
			prev_reg    <= 2'h3;
			fcnt_reg[0] <= 4'h0;
			fcnt_reg[1] <= 4'h0;
		end else begin
			prev_reg <= filt_reg;
			for (int i = 0; i < 2; i++) begin
				if (s2_reg[i] == filt_reg[i]) begin
					fcnt_reg[i] <= 4'h0;
				end else if (fcnt_reg[i] >= glitch_cfg_reg[3:0]) begin
					filt_reg[i] <= s2_reg[i];
					fcnt_reg[i] <= 4'h0;
				end else begin
					fcnt_reg[i] <= fcnt_reg[i] + 4'h1;
				end
			end
		end
	end

	assign scl_rise   = filt_reg[0] & ~prev_reg[0];
	assign scl_fall   = ~filt_reg[0] & prev_reg[0];
	// Clock taken from the bus only, never driven
	assign start_cond = filt_reg[0] & prev_reg[0] & prev_reg[1] &
		~filt_reg[1];
	assign stop_cond  = filt_reg[0] & prev_reg[0] & ~prev_reg[1] &
		filt_reg[1];

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			strap_cnt_reg  <= 2'h0;
			strap_done_reg <= 1'b0;
			slave_addr     <= aamp_pkg::DEV_ADDR_BASE;
		end else if (!strap_done_reg) begin
			if (strap_cnt_reg == aamp_pkg::STRAP_SETTLE) begin
				slave_addr     <= 7'(aamp_pkg::DEV_ADDR_BASE +
					{5'h00, s2_reg[3], s2_reg[2]});
				strap_done_reg <= 1'b1;
			end else begin
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
			end
		end
	end

	assign byte_done = scl_fall & ~start_cond & ~stop_cond &
		(state_reg == aamp_pkg::ST_DATA) & (bit_reg == aamp_pkg::BITS_PER_BYTE);
	assign word_done = byte_done & coef_mode &
		(bidx_reg == aamp_pkg::LAST_BYTE_IDX);
	assign full_word = {word_reg, rx_reg};
	assign slot      = aamp_pkg::coef_slot(addr_reg);
	assign rd_byte   = coef_mode ?
		8'(reg_rd_data >> {~bidx_reg, 3'h0}) : reg_rd_data[7:0];
	assign reg_rd_addr = addr_reg;
	assign busy        = state_reg != aamp_pkg::ST_IDLE;
	assign glitch_cfg  = glitch_cfg_reg;
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = sda_drive_reg;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg     <= aamp_pkg::ST_IDLE;
			bit_reg       <= 4'h0;
			rx_reg        <= 8'h00;
			tx_reg        <= 8'h00;
			ack_ok_reg    <= 1'b0;
			aif_reg       <= 1'b0;
			sda_drive_reg <= 1'b0;
			addr_reg      <= 7'h00;
			bidx_reg      <= 2'h0;
			word_reg      <= 24'h000000;
		end else if (start_cond) begin
			state_reg     <= aamp_pkg::ST_ADDR;
			bit_reg       <= 4'h0;
			sda_drive_reg <= 1'b0;
		end else if (stop_cond) begin
			state_reg     <= aamp_pkg::ST_IDLE;
			bit_reg       <= 4'h0;
			sda_drive_reg <= 1'b0;
		end else if (busy && scl_rise) begin
			if (bit_reg < aamp_pkg::BITS_PER_BYTE) begin
				rx_reg <= {rx_reg[6:0], filt_reg[1]};
			end else begin
				ack_ok_reg <= ~filt_reg[1];
			end
			bit_reg <= bit_reg + 4'h1;
		end else if (busy && scl_fall) begin
			if (bit_reg == aamp_pkg::ACK_DONE) begin
				bit_reg       <= 4'h0;
				sda_drive_reg <= 1'b0;
				if (state_reg == aamp_pkg::ST_RD) begin
					if (ack_ok_reg) begin
						tx_reg        <= rd_byte;
						sda_drive_reg <= ~rd_byte[7];
						if (coef_mode && bidx_reg != aamp_pkg::LAST_BYTE_IDX) begin
							bidx_reg <= bidx_reg + 2'h1;
						end else begin
							bidx_reg <= 2'h0;
							if (aif_reg) begin
								addr_reg <= aamp_pkg::next_addr(coef_mode,
									addr_reg);
							end
						end
					end else begin
						state_reg <= aamp_pkg::ST_IGNORE;
					end
				end
			end else if (bit_reg == aamp_pkg::BITS_PER_BYTE) begin
				case (state_reg)
				aamp_pkg::ST_ADDR: begin
					if (rx_reg[7:1] == slave_addr) begin
						sda_drive_reg <= 1'b1;
						state_reg     <= rx_reg[0] ? aamp_pkg::ST_RD :
							aamp_pkg::ST_SUB;
					end else begin
						state_reg <= aamp_pkg::ST_IGNORE;
					end
				end
				aamp_pkg::ST_SUB: begin
					aif_reg       <= rx_reg[7];
					addr_reg      <= rx_reg[6:0];
					bidx_reg      <= 2'h0;
					sda_drive_reg <= 1'b1;
					state_reg     <= aamp_pkg::ST_DATA;
				end
				aamp_pkg::ST_DATA: begin
					sda_drive_reg <= 1'b1;
					if (coef_mode && !word_done) begin
						word_reg <= {word_reg[15:0], rx_reg};
						bidx_reg <= bidx_reg + 2'h1;
					end else begin
						bidx_reg <= 2'h0;
						if (aif_reg) begin
							addr_reg <= aamp_pkg::next_addr(coef_mode,
								addr_reg);
						end else begin
							state_reg <= aamp_pkg::ST_SUB;
						end
					end
				end
				default: begin
					sda_drive_reg <= 1'b0;
				end
				endcase
			end else if (state_reg == aamp_pkg::ST_RD && bit_reg != 4'h0) begin
				tx_reg        <= {tx_reg[6:0], 1'b0};
				sda_drive_reg <= ~tx_reg[6];
			end
		end
	end

	// Single-byte register writes, glitch filter setting kept locally
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_wr_stb     <= 1'b0;
			reg_wr_addr    <= 7'h00;
			reg_wr_data    <= 8'h00;
			glitch_cfg_reg <= aamp_pkg::GLITCH_CFG_RST;
		end else begin
			reg_wr_stb <= byte_done & ~coef_mode;
			if (byte_done && !coef_mode) begin
				reg_wr_addr <= addr_reg;
				reg_wr_data <= rx_reg;
				if (addr_reg == aamp_pkg::GLITCH_CFG_ADDR) begin
					glitch_cfg_reg <= rx_reg;
				end
			end
		end
	end

	// First four coefficients of a filter wait here
	always_ff @(posedge core_clk) begin
		if (word_done && slot != aamp_pkg::LAST_COEF_SLOT) begin
			stage_mem[slot[1:0]] <= full_word;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			coef_wr_stb      <= 1'b0;
			coef_wr_addr     <= 7'h00;
			coef_wr_data     <= 32'h00000000;
			coef_commit_stb  <= 1'b0;
			coef_commit_addr <= 7'h00;
			coef_commit_data <= '0;
		end else begin
			coef_wr_stb     <= word_done;
			coef_commit_stb <= word_done &&
				slot == aamp_pkg::LAST_COEF_SLOT &&
				addr_reg <= aamp_pkg::COEF_FILT_TOP;
			if (word_done) begin
				coef_wr_addr <= addr_reg;
				coef_wr_data <= full_word;
			end
			if (word_done && slot == aamp_pkg::LAST_COEF_SLOT &&
				addr_reg <= aamp_pkg::COEF_FILT_TOP) begin
				coef_commit_addr <= 7'(addr_reg - 7'h04);
				coef_commit_data <= {stage_mem[0], stage_mem[1],
					stage_mem[2], stage_mem[3], full_word};
			end
		end
	end
endmodule

// file: hdl/aamp_i2c_host.sv
`timescale 1ns/10ps
module aamp_i2c_host #(
	parameter int QTR_CYC = aamp_pkg::SCL_QTR_CYC
) (
	input  wire logic          core_clk,
	input  wire logic          nrst,
	aamp_link_if.host          link,
	input  wire logic [6:0]    target_addr,
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire logic          cmd_read,
	input  wire logic          cmd_aif,
	input  wire logic [6:0]    cmd_sub,
	input  wire logic [2:0]    cmd_count,
	input  wire logic [31:0]   cmd_wdata,
	output logic [31:0]        rd_data,
	output logic               done,
	output logic               nak_err
);
	logic                          sda_s1_reg;
	logic                          sda_s2_reg;
	aamp_pkg::aamp_host_state_t    state_reg;
	logic [7:0]                    q_reg;
	logic [1:0]                    ph_reg;
	logic [3:0]                    bit_reg;
	logic [2:0]                    byte_reg;
	logic [2:0]                    rem_reg;
	logic                          rdph_reg;
	logic                          read_reg;
	logic [6:0]                    addr_reg;
	logic [7:0]                    tx_reg;
	logic [7:0]                    rx_reg;
	logic [31:0]                   wsh_reg;
	logic                          nak_reg;
	logic                          scl_lo_reg;
	logic                          sda_lo_reg;
	logic                          tick;
	logic                          reading;
	logic                          data_byte;

	assign tick      = q_reg == 8'(QTR_CYC - 1);
	assign reading   = rdph_reg && byte_reg != 3'h0;
	assign data_byte = rdph_reg ? byte_reg != 3'h0 : byte_reg >= 3'h2;
	assign cmd_ready = state_reg == aamp_pkg::H_IDLE;
	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = scl_lo_reg;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = sda_lo_reg;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
		end else begin
			sda_s1_reg <= link.sda;
			sda_s2_reg <= sda_s1_reg;
		end
	end

	// Four quarter phases per bit: low, high, high, low
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q_reg  <= 8'h00;
			ph_reg <= 2'h0;
		end else if (cmd_ready) begin
			q_reg  <= 8'h00;
			ph_reg <= 2'h0;
		end else if (tick) begin
			q_reg  <= 8'h00;
			ph_reg <= ph_reg + 2'h1;
		end else begin
			q_reg <= q_reg + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= aamp_pkg::H_IDLE;
			bit_reg    <= 4'h0;
			byte_reg   <= 3'h0;
			rem_reg    <= 3'h0;
			rdph_reg   <= 1'b0;
			read_reg   <= 1'b0;
			addr_reg   <= 7'h00;
			tx_reg     <= 8'h00;
			rx_reg     <= 8'h00;
			wsh_reg    <= 32'h00000000;
			nak_reg    <= 1'b0;
			scl_lo_reg <= 1'b0;
			sda_lo_reg <= 1'b0;
			rd_data    <= 32'h00000000;
			done       <= 1'b0;
			nak_err    <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
			aamp_pkg::H_IDLE: begin
				if (cmd_valid) begin
					read_reg  <= cmd_read;
					addr_reg  <= target_addr;
					tx_reg    <= {target_addr, 1'b0};
					bit_reg   <= 4'h0;
					byte_reg  <= 3'h0;
					rdph_reg  <= 1'b0;
					rem_reg   <= cmd_count;
					wsh_reg   <= cmd_wdata << {3'(aamp_pkg::MAX_BYTES -
						cmd_count), 3'h0};
					rx_reg    <= {cmd_aif, cmd_sub};
					nak_err   <= 1'b0;
					state_reg <= aamp_pkg::H_START;
				end
			end
			aamp_pkg::H_START, aamp_pkg::H_RESTART: begin
				if (tick) begin
					case (ph_reg)
					2'h0: scl_lo_reg <= 1'b0;
					2'h1: sda_lo_reg <= 1'b1;
					2'h2: scl_lo_reg <= 1'b1;
					default: begin
						sda_lo_reg <= ~tx_reg[7];
						state_reg  <= aamp_pkg::H_BIT;
					end
					endcase
				end
			end
			aamp_pkg::H_STOP: begin
				if (tick) begin
					case (ph_reg)
					2'h0: scl_lo_reg <= 1'b0;
					2'h1: sda_lo_reg <= 1'b0;
					default: begin
						done      <= 1'b1;
						state_reg <= aamp_pkg::H_IDLE;
					end
					endcase
				end
			end
			aamp_pkg::H_BIT: begin
				if (tick) begin
					case (ph_reg)
					2'h0: scl_lo_reg <= 1'b0;
					2'h1: begin
						if (bit_reg < aamp_pkg::BITS_PER_BYTE) begin
							rx_reg <= {rx_reg[6:0], sda_s2_reg};
						end else begin
							nak_reg <= sda_s2_reg;
						end
					end
					2'h2: scl_lo_reg <= 1'b1;
					default: begin
						if (bit_reg != aamp_pkg::BITS_PER_BYTE) begin
							bit_reg <= bit_reg + 4'h1;
							tx_reg  <= {tx_reg[6:0], 1'b0};
							if (bit_reg == 4'h7) begin
								sda_lo_reg <= reading && rem_reg != 3'h1;
							end else begin
								sda_lo_reg <= !reading && !tx_reg[6];
							end
						end else begin
							bit_reg <= 4'h0;
							if (reading) begin
								rd_data <= {rd_data[23:0], rx_reg};
							end
							if (!reading && nak_reg) begin
								nak_err    <= 1'b1;
								sda_lo_reg <= 1'b1;
								state_reg  <= aamp_pkg::H_STOP;
							end else if (data_byte && rem_reg == 3'h1) begin
								sda_lo_reg <= 1'b1;
								state_reg  <= aamp_pkg::H_STOP;
							end else if (!rdph_reg && byte_reg == 3'h1 &&
								read_reg) begin
								rdph_reg   <= 1'b1;
								byte_reg   <= 3'h0;
								tx_reg     <= {addr_reg, 1'b1};
								sda_lo_reg <= 1'b0;
								state_reg  <= aamp_pkg::H_RESTART;
							end else begin
								byte_reg <= byte_reg + 3'h1;
								if (data_byte) begin
									rem_reg <= rem_reg - 3'h1;
								end
								if (!rdph_reg && byte_reg == 3'h0) begin
									tx_reg     <= {cmd_aif, cmd_sub};
									sda_lo_reg <= ~cmd_aif;
								end else if (rdph_reg) begin
									sda_lo_reg <= 1'b0;
								end else begin
									tx_reg     <= wsh_reg[31:24];
									wsh_reg    <= wsh_reg << 8;
									sda_lo_reg <= ~wsh_reg[31];
								end
							end
						end
					end
					endcase
				end
			end
			default: state_reg <= aamp_pkg::H_IDLE;
			endcase
		end
	end
endmodule

// file: testbench/aamp_link_chk.sv
`timescale 1ns/10ps
module aamp_link_chk #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe
);
	logic       scl_d, sda_d, in_frame, first_byte, rd_dir, no_match;
	logic       rise, start_c, stop_c;
	logic [3:0] bit_cnt;
	logic [6:0] shift_reg;

	assign rise    = scl & ~scl_d;
	assign start_c = scl & scl_d & sda_d & ~sda;
	assign stop_c  = scl & scl_d & ~sda_d & sda;

	// Bit slot, first byte and direction of the running frame
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			in_frame <= 1'b0;
			first_byte <= 1'b0;
			rd_dir <= 1'b0;
			no_match <= 1'b0;
			bit_cnt <= 4'h0;
			shift_reg <= 7'h00;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			if (start_c) begin
				in_frame <= 1'b1;
				first_byte <= 1'b1;
				no_match <= 1'b0;
				bit_cnt <= 4'h0;
			end else if (stop_c) begin
				in_frame <= 1'b0;
			end else if (rise) begin
				bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
				shift_reg <= {shift_reg[5:0], sda};
				if (first_byte && bit_cnt == 4'h7) begin
					no_match <= shift_reg != SLAVE_ADDR;
					rd_dir <= sda;
				end
				if (first_byte && bit_cnt == 4'h8)
					first_byte <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	a_drive_clk_low: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("device took data line with clock high");
	a_drive_in_frame: assert property ($rose(dev_sda_oe) |-> in_frame)
		else $error("device drove data line outside a frame");
	a_start_free: assert property (start_c |-> !dev_sda_oe)
		else $error("device held data line at a start");
	a_cond_slot: assert property (
		(start_c || stop_c) && in_frame |-> bit_cnt == 4'h1)
		else $error("start or stop inside a byte");
	a_write_ack: assert property (
		rise && bit_cnt == 4'h8 && in_frame && !no_match &&
		(first_byte || !rd_dir) |-> dev_sda_oe && !dev_sda_o)
		else $error("missing acknowledge");
	a_read_release: assert property (
		rise && bit_cnt == 4'h8 && in_frame && !first_byte && rd_dir &&
		!no_match |-> !dev_sda_oe)
		else $error("device held data line in host ack slot");
	a_write_quiet: assert property (
		rise && bit_cnt != 4'h8 && in_frame && !first_byte && !rd_dir &&
		!no_match |-> !dev_sda_oe)
		else $error("device drove data bits of a write");
	a_nomatch_quiet: assert property (
		no_match && in_frame |-> ##1 !dev_sda_oe [*3])
		else $error("device answered another address");
endmodule

// file: testbench/tb_audio_amp_i2c_slave_port.sv
`timescale 1ns/10ps
`define CHK(got, exp, msg) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("MISMATCH %0t %s", $time, msg); \
		end \
	end
module tb_audio_amp_i2c_slave_port;
	logic         core_clk, nrst, addr_sel, strap_in, coef_mode, busy;
	logic         cmd_valid, cmd_ready, cmd_read, cmd_aif, done, nak_err;
	logic         reg_wr_stb, coef_wr_stb, coef_commit_stb;
	logic [6:0]   target_addr, cmd_sub, reg_rd_addr, reg_wr_addr;
	logic [6:0]   coef_wr_addr, coef_commit_addr, slave_addr;
	logic [2:0]   cmd_count;
	logic [31:0]  cmd_wdata, rd_data, reg_rd_data, coef_wr_data;
	logic [7:0]   reg_wr_data, glitch_cfg;
	logic [159:0] coef_commit_data;
	logic [166:0] last_commit;
	logic [38:0]  last_cw;
	logic [14:0]  wr_q[$];
	int           mismatches, num_checks, commits;

	aamp_link_if link ();
	aamp_i2c_dev aamp_i2c_dev_inst (
		.core_clk(core_clk), .nrst(nrst), .link(link),
		.addr_sel(addr_sel), .strap_in(strap_in), .coef_mode(coef_mode),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
		.reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data), .coef_wr_stb(coef_wr_stb),
		.coef_wr_addr(coef_wr_addr), .coef_wr_data(coef_wr_data),
		.coef_commit_stb(coef_commit_stb),
		.coef_commit_addr(coef_commit_addr),
		.coef_commit_data(coef_commit_data), .slave_addr(slave_addr),
		.glitch_cfg(glitch_cfg), .busy(busy));
	aamp_i2c_host #(.QTR_CYC(10)) aamp_i2c_host_inst (
		.core_clk(core_clk), .nrst(nrst), .link(link),
		.target_addr(target_addr), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_aif(cmd_aif),
		.cmd_sub(cmd_sub), .cmd_count(cmd_count), .cmd_wdata(cmd_wdata),
		.rd_data(rd_data), .done(done), .nak_err(nak_err));
	aamp_link_chk #(.SLAVE_ADDR(7'h2a)) aamp_link_chk_inst (
		.core_clk(core_clk), .nrst(nrst), .scl(link.scl), .sda(link.sda),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));

	function automatic logic [31:0] rd_model(input logic [6:0] a);
		rd_model = {8'hc3, 1'b0, a, 8'h96, 1'b1, a};
	endfunction
	assign reg_rd_data = rd_model(reg_rd_addr);

	always @(posedge core_clk) begin
		if (reg_wr_stb)
			wr_q.push_back({reg_wr_addr, reg_wr_data});
		if (coef_wr_stb)
			last_cw = {coef_wr_addr, coef_wr_data};
		if (coef_commit_stb) begin
			commits++;
			last_commit = {coef_commit_addr, coef_commit_data};
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic reset_dut(input logic a, input logic s);
		nrst = 1'b0;
		addr_sel = a;
		strap_in = s;
		repeat (4) @(posedge core_clk);
		#2;
		nrst = 1'b1;
		repeat (6) @(posedge core_clk);
		#2;
	endtask

	task automatic run(input logic rd, input logic auto_increment_flag, input logic [6:0] sub,
		input logic [2:0] n, input logic [31:0] wd);
		int i;
		cmd_read = rd;
		cmd_aif = auto_increment_flag;
		cmd_sub = sub;
		cmd_count = n;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		@(posedge core_clk);
		#2;
		cmd_valid = 1'b0;
		i = 0;
		while (done !== 1'b1) begin
			@(posedge core_clk);
			#2;
			i++;
			if (i > 20000) begin
				mismatches++;
				$display("MISMATCH %0t no completion", $time);
				final_report();
			end
		end
		`CHK(busy, 1'b0, "device busy after stop")
		`CHK(cmd_ready, 1'b1, "host not ready after stop")
	endtask

	task automatic exp_wr(input logic [6:0] a, input logic [7:0] d);
		logic [14:0] e;
		e = 15'h7fff;
		if (wr_q.size() > 0)
			e = wr_q.pop_front();
		`CHK(e, {a, d}, "register write")
	endtask

	task automatic t_strap();
		for (int k = 0; k < 4; k++) begin
			reset_dut(k[0], k[1]);
			`CHK({slave_addr, 1'b0}, 8'h54 + {k[1:0], 1'b0}, "address")
			`CHK(glitch_cfg, 8'h03, "filter reset")
		end
		reset_dut(1'b0, 1'b0);
	endtask

	task automatic t_mismatch();
		target_addr = 7'h2b;
		run(1'b0, 1'b0, 7'h10, 3'h1, 32'h55);
		`CHK(nak_err, 1'b1, "foreign address answered")
		`CHK(wr_q.size(), 0, "foreign address wrote")
		target_addr = 7'h2a;
	endtask

	task automatic t_writes();
		run(1'b0, 1'b0, 7'h12, 3'h1, 32'ha7);
		`CHK(nak_err, 1'b0, "write refused")
		exp_wr(7'h12, 8'ha7);
		// Second pair: plain address byte 0x21, then its data
		run(1'b0, 1'b0, 7'h20, 3'h3, 32'h112122);
		exp_wr(7'h20, 8'h11);
		exp_wr(7'h21, 8'h22);
		run(1'b0, 1'b1, 7'h7e, 3'h3, 32'h334455);
		exp_wr(7'h7e, 8'h33);
		exp_wr(7'h7f, 8'h44);
		exp_wr(7'h00, 8'h55);
	endtask

	task automatic t_reads();
		logic [31:0] a;
		logic [31:0] b;
		a = rd_model(7'h7f);
		b = rd_model(7'h00);
		run(1'b1, 1'b1, 7'h7f, 3'h2, 32'h0);
		`CHK(rd_data[15:0], {a[7:0], b[7:0]}, "increment read")
		a = rd_model(7'h05);
		run(1'b1, 1'b0, 7'h05, 3'h1, 32'h0);
		`CHK(rd_data[7:0], a[7:0], "single read")
	endtask

	task automatic t_coef();
		logic [159:0] w;
		coef_mode = 1'b1;
		for (int k = 0; k < 5; k++) begin
			`CHK(commits, 0, "early commit")
			w[159 - 32 * k -: 32] = 32'h13579bdf + 32'(k) * 32'h01010101;
			run(1'b0, 1'b0, 7'(k), 3'h4, w[159 - 32 * k -: 32]);
		end
		`CHK(last_cw, {7'h04, w[31:0]}, "coefficient word")
		`CHK(commits, 1, "commit count")
		`CHK(last_commit, {7'h00, w}, "committed set")
		run(1'b1, 1'b0, 7'h03, 3'h4, 32'h0);
		`CHK(rd_data, rd_model(7'h03), "quad read")
		coef_mode = 1'b0;
	endtask

	task automatic t_glitch();
		run(1'b0, 1'b0, 7'h66, 3'h1, 32'h01);
		`CHK(glitch_cfg, 8'h01, "filter setting")
		exp_wr(7'h66, 8'h01);
		run(1'b0, 1'b0, 7'h13, 3'h1, 32'h3c);
		exp_wr(7'h13, 8'h3c);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		nrst = 1'b0;
		addr_sel = 1'b0;
		strap_in = 1'b0;
		coef_mode = 1'b0;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_aif = 1'b0;
		cmd_sub = 7'h00;
		cmd_count = 3'h1;
		cmd_wdata = 32'h0;
		target_addr = 7'h2a;
		mismatches = 0;
		num_checks = 0;
		commits = 0;
		#2;
		t_strap();
		t_mismatch();
		t_writes();
		t_reads();
		t_coef();
		t_glitch();
		final_report();
	end
endmodule
